// ### logic/wuc_params.svh
`ifndef WUC_PARAMS_SVH
`define WUC_PARAMS_SVH
`define WUC_AW 8
`define WUC_DW 32
`define WUC_CTRL_OFS 8'h68
`define WUC_PDATA_OFS 8'h70
`define WUC_PPTR_OFS 8'h74
`define WUC_IMASK_OFS 8'h78
`define WUC_B_SEED 30
`define WUC_B_WP1 29
`define WUC_B_WP2 28
`define WUC_B_WP3 27
`define WUC_B_WP4 26
`define WUC_B_WP5 25
`define WUC_B_LOFF 17
`define WUC_B_LON 16
`define WUC_B_FRAME_EN 10
`define WUC_B_PKT_EN 9
`define WUC_B_LINK_EN 8
`define WUC_B_FRAME_FLAG 2
`define WUC_B_PKT_FLAG 1
`define WUC_B_LINK_FLAG 0
`define WUC_NFLAG 3
`define WUC_CTRL_WMASK 32'h7e03_0700
`define WUC_CTRL_RSVD 32'h0000_0800
`define WUC_CTRL_RST 32'h0000_0000
`define WUC_NPAT 6
`define WUC_PW 5
`define WUC_WPP 5'h5
`define WUC_CRC_SLOT 5'h4
`define WUC_NWORD 5'h1e
`define WUC_CRCW_KEEP 32'hffff_00ff
`define WUC_CRC_POLY 16'h8005
`define WUC_SEED_ONE 16'hffff
`define WUC_SEED_ZERO 16'h0000
`define WUC_CW 11
`define WUC_CNT_MAX 11'h7ff
`define WUC_F_CRC 31:16
`define WUC_F_OFS 7:0
`define WUC_F_MHI 10:7
`define WUC_F_MWORD 6:5
`define WUC_F_MBIT 4:0
`endif

// ### logic/wuc_pkg.sv
`include "wuc_params.svh"
package wuc_pkg;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [`WUC_AW-1:0] addr;
		logic [`WUC_DW-1:0] wdata;
	} wuc_bus_s;
	typedef struct packed {
		logic valid;
		logic sof;
		logic eof;
		logic ok;
		logic [7:0] data;
	} wuc_frame_s;
	typedef enum logic [1:0] {
		WUC_FR_IDLE = 2'b01,
		WUC_FR_BODY = 2'b10
	} wuc_frame_e;
	typedef logic [`WUC_NFLAG-1:0] wuc_flag_t;
endpackage

// ### logic/wuc_top.sv
// Contract
// - Control bits 26 and 25 enable pattern four and five wake; reset zero.
// - With bit 17 set, link going down sets the link change flag.
// - With bit 16 set, link coming up sets the link change flag.
// - With bit 10 set, a matched wake frame raises power event status.
// - With bit 9 set, a remote wake packet raises power event status.
// - With bit 8 set, a link change raises power event status.
// - Status bit 2 latches a received wake frame until cleared.
// - Status bit 1 latches a received remote wake packet until cleared.
// - Status bit 0 latches a link change event until cleared.
// - Flags clear only by write one or power-up reset, not system reset.
// - All six patterns load through one data port, words taken successively.
// - Each pattern starts with four mask words, bits 31:0 up to 127:96.
// - Fifth word holds CRC-16 in 31:16, reserved 15:8, offset 7:0.
// - Seed select bit picks CRC start of all zeros or all ones.
// - Control bits 29, 28, 27 enable patterns one to three; reset zero.
`timescale 1ns/100ps
`default_nettype none
`include "wuc_params.svh"
module wuc_top import wuc_pkg::*; (
	// Clock and resets
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic pwr_on_rst,
	// Register port
	input wire wuc_bus_s bus,
	output logic [`WUC_DW-1:0] rdata,
	// Network side
	input wire wuc_frame_s frame,
	input wire logic remote_pkt_seen,
	input wire logic link_up,
	// Power management
	output logic power_event_status,
	output logic irq
);

	logic [`WUC_DW-1:0] ctrl;
	logic [`WUC_DW-1:0] next_ctrl;
	wuc_flag_t flags;
	wuc_flag_t next_flags;
	wuc_flag_t flag_set;
	wuc_flag_t flag_clr;
	wuc_flag_t irq_mask;
	wuc_flag_t next_irq_mask;
	logic [`WUC_DW-1:0] filt [`WUC_NWORD];
	logic [`WUC_DW-1:0] next_filt [`WUC_NWORD];
	logic [`WUC_PW-1:0] wptr;
	logic [`WUC_PW-1:0] next_wptr;
	logic [`WUC_DW-1:0] next_rdata;
	logic link_prev;
	logic next_power_event_status;
	wuc_frame_e fstate;
	wuc_frame_e next_fstate;
	logic [`WUC_CW-1:0] bcnt;
	logic [`WUC_CW-1:0] next_bcnt;
	logic [`WUC_CW-1:0] idx;
	logic [`WUC_CW-1:0] rel;
	logic [15:0] crc [`WUC_NPAT];
	logic [15:0] next_crc [`WUC_NPAT];
	logic [15:0] base;
	logic [15:0] seed;
	logic [`WUC_NPAT-1:0] pat_sel;
	logic [`WUC_NPAT-1:0] pat_hit;
	logic [`WUC_NPAT-1:0] pat_en;
	logic in_frame;
	logic link_rise;
	logic link_fall;
	logic link_evt;
	logic frame_evt;
	logic pkt_evt;
	logic wr_ctrl;
	logic wr_pdata;
	logic rd_pdata;
	logic wr_pptr;
	logic wr_imask;
	logic pattern_one_wake_enable;
	logic pattern_two_wake_enable;
	logic pattern_three_wake_enable;
	logic pattern_four_wake_enable;
	logic pattern_five_wake_enable;
	logic link_down_detect_enable;
	logic link_up_detect_enable;
	logic frame_wake_enable;
	logic remote_wake_packet_enable;
	logic link_change_wake_enable;
	logic crc_seed_select;
	logic wake_frame_seen_flag;
	logic remote_wake_packet_flag;
	logic link_change_flag;

	// One byte through CRC-16, most significant bit first
	function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			r = {r[14:0], 1'b0} ^ ((r[15] ^ d[7-i]) ? `WUC_CRC_POLY : 16'h0);
		end
		return r;
	endfunction

	// Storage index with wrap after the last word
	function automatic logic [`WUC_PW-1:0] ptr_inc(input logic [`WUC_PW-1:0] p);
		return (p >= `WUC_NWORD - 5'h1) ? 5'h0 : p + 5'h1;
	endfunction

	function automatic logic is_crc_word(input logic [`WUC_PW-1:0] p);
		return (p % `WUC_WPP) == `WUC_CRC_SLOT;
	endfunction

	assign wr_ctrl = bus.wr && (bus.addr == `WUC_CTRL_OFS);
	assign wr_pdata = bus.wr && (bus.addr == `WUC_PDATA_OFS);
	assign rd_pdata = bus.rd && (bus.addr == `WUC_PDATA_OFS);
	assign wr_pptr = bus.wr && (bus.addr == `WUC_PPTR_OFS);
	assign wr_imask = bus.wr && (bus.addr == `WUC_IMASK_OFS);

	assign crc_seed_select = ctrl[`WUC_B_SEED];
	assign pattern_one_wake_enable = ctrl[`WUC_B_WP1];
	assign pattern_two_wake_enable = ctrl[`WUC_B_WP2];
	assign pattern_three_wake_enable = ctrl[`WUC_B_WP3];
	assign pattern_four_wake_enable = ctrl[`WUC_B_WP4];
	assign pattern_five_wake_enable = ctrl[`WUC_B_WP5];
	assign link_down_detect_enable = ctrl[`WUC_B_LOFF];
	assign link_up_detect_enable = ctrl[`WUC_B_LON];
	assign frame_wake_enable = ctrl[`WUC_B_FRAME_EN];
	assign remote_wake_packet_enable = ctrl[`WUC_B_PKT_EN];
	assign link_change_wake_enable = ctrl[`WUC_B_LINK_EN];
	assign wake_frame_seen_flag = flags[`WUC_B_FRAME_FLAG];
	assign remote_wake_packet_flag = flags[`WUC_B_PKT_FLAG];
	assign link_change_flag = flags[`WUC_B_LINK_FLAG];

	// Pattern six has no enable bit and never wakes
	assign pat_en = {1'b0, pattern_five_wake_enable, pattern_four_wake_enable,
		pattern_three_wake_enable, pattern_two_wake_enable, pattern_one_wake_enable};
	assign seed = crc_seed_select ? `WUC_SEED_ONE : `WUC_SEED_ZERO;

	// Frame scan and per-pattern CRC
	always_comb begin
		next_fstate = fstate;
		next_bcnt = bcnt;
		pat_sel = '0;
		pat_hit = '0;
		rel = '0;
		base = '0;
		for (int p = 0; p < `WUC_NPAT; p++) begin
			next_crc[p] = crc[p];
		end
		case (fstate)
			WUC_FR_IDLE: in_frame = frame.sof;
			WUC_FR_BODY: in_frame = 1'b1;
			default: in_frame = 1'b0;
		endcase
		idx = frame.sof ? '0 : bcnt;
		if (frame.valid && in_frame) begin
			for (int p = 0; p < `WUC_NPAT; p++) begin
				base = frame.sof ? seed : crc[p];
				rel = idx - {3'h0, filt[p*`WUC_WPP+`WUC_CRC_SLOT][`WUC_F_OFS]};
				if ((idx >= {3'h0, filt[p*`WUC_WPP+`WUC_CRC_SLOT][`WUC_F_OFS]})
					&& (rel[`WUC_F_MHI] == 4'h0)) begin
					pat_sel[p] = filt[p*`WUC_WPP+rel[`WUC_F_MWORD]][rel[`WUC_F_MBIT]];
				end
				next_crc[p] = pat_sel[p] ? crc16_byte(base, frame.data) : base;
				pat_hit[p] = next_crc[p] == filt[p*`WUC_WPP+`WUC_CRC_SLOT][`WUC_F_CRC];
			end
			next_bcnt = (idx == `WUC_CNT_MAX) ? idx : idx + 11'h1;
			next_fstate = frame.eof ? WUC_FR_IDLE : WUC_FR_BODY;
		end
	end

	assign frame_evt = frame.valid && frame.eof && frame.ok && in_frame && |(pat_hit & pat_en);
	assign pkt_evt = remote_pkt_seen;
	assign link_rise = link_up && !link_prev;
	assign link_fall = !link_up && link_prev;
	assign link_evt = (link_fall && link_down_detect_enable)
		|| (link_rise && link_up_detect_enable);

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			fstate <= WUC_FR_IDLE;
			bcnt <= '0;
			link_prev <= link_up;
			for (int p = 0; p < `WUC_NPAT; p++) begin
				crc[p] <= '0;
			end
		end else begin
			fstate <= next_fstate;
			bcnt <= next_bcnt;
			link_prev <= link_up;
			for (int p = 0; p < `WUC_NPAT; p++) begin
				crc[p] <= next_crc[p];
			end
		end
	end

	// Sticky flags, set wins over a write-one clear
	always_comb begin
		flag_set = '0;
		flag_set[`WUC_B_FRAME_FLAG] = frame_evt;
		flag_set[`WUC_B_PKT_FLAG] = pkt_evt;
		flag_set[`WUC_B_LINK_FLAG] = link_evt;
		flag_clr = wr_ctrl ? bus.wdata[`WUC_NFLAG-1:0] : '0;
		next_flags = (flags & ~flag_clr) | flag_set;
	end

	// Of the two resets, only power-up reset clears flags and filter words
	always_ff @(posedge clock) begin
		if (pwr_on_rst) begin
			flags <= '0;
			for (int w = 0; w < `WUC_NWORD; w++) begin
				filt[w] <= '0;
			end
		end else begin
			flags <= next_flags;
			for (int w = 0; w < `WUC_NWORD; w++) begin
				filt[w] <= next_filt[w];
			end
		end
	end

	// Register file
	always_comb begin
		next_ctrl = ctrl;
		next_irq_mask = irq_mask;
		next_wptr = wptr;
		for (int w = 0; w < `WUC_NWORD; w++) begin
			next_filt[w] = filt[w];
		end
		if (wr_ctrl) begin
			next_ctrl = bus.wdata & `WUC_CTRL_WMASK;
		end
		if (wr_imask) begin
			next_irq_mask = bus.wdata[`WUC_NFLAG-1:0];
		end
		if (wr_pdata) begin
			next_filt[wptr] = is_crc_word(wptr) ? (bus.wdata & `WUC_CRCW_KEEP) : bus.wdata;
			next_wptr = ptr_inc(wptr);
		end else if (rd_pdata) begin
			next_wptr = ptr_inc(wptr);
		end else if (wr_pptr) begin
			next_wptr = (bus.wdata[`WUC_PW-1:0] < `WUC_NWORD) ? bus.wdata[`WUC_PW-1:0] : '0;
		end
		next_rdata = '0;
		if (bus.rd) begin
			case (bus.addr)
				`WUC_CTRL_OFS: next_rdata = ctrl | `WUC_CTRL_RSVD | {29'h0, flags};
				`WUC_PDATA_OFS: next_rdata = filt[wptr];
				`WUC_PPTR_OFS: next_rdata = {27'h0, wptr};
				`WUC_IMASK_OFS: next_rdata = {29'h0, irq_mask};
				default: next_rdata = '0;
			endcase
		end
		next_power_event_status = (wake_frame_seen_flag && frame_wake_enable)
			|| (remote_wake_packet_flag && remote_wake_packet_enable)
			|| (link_change_flag && link_change_wake_enable);
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			ctrl <= `WUC_CTRL_RST;
			irq_mask <= '0;
			wptr <= '0;
			rdata <= '0;
			power_event_status <= 1'b0;
		end else begin
			ctrl <= next_ctrl;
			irq_mask <= next_irq_mask;
			wptr <= next_wptr;
			rdata <= next_rdata;
			power_event_status <= next_power_event_status;
		end
	end

	assign irq = |(flags & irq_mask);

	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst || pwr_on_rst);

	sequence s_ctrl_wr(int b);
		wr_ctrl && bus.wdata[b];
	endsequence
	sequence s_ctrl_rd;
		bus.rd && (bus.addr == `WUC_CTRL_OFS);
	endsequence
	sequence s_quiet;
		!wr_ctrl;
	endsequence

	property p_wp4_en;
		s_ctrl_wr(`WUC_B_WP4) ##1 s_quiet ##1 s_ctrl_rd |=> rdata[`WUC_B_WP4];
	endproperty
	a_wp4_en: assert property (p_wp4_en) else $error("pattern four enable not kept");
	property p_wp5_en;
		s_ctrl_wr(`WUC_B_WP5) ##1 s_quiet ##1 s_ctrl_rd |=> rdata[`WUC_B_WP5];
	endproperty
	a_wp5_en: assert property (p_wp5_en) else $error("pattern five enable not kept");
	property p_en_rst;
		disable iff (pwr_on_rst) sys_rst |=> (ctrl[`WUC_B_WP1:`WUC_B_WP5] == 5'h0);
	endproperty
	a_en_rst: assert property (p_en_rst) else $error("pattern enables not cleared");
	property p_link_down;
		link_fall && link_down_detect_enable |=> link_change_flag;
	endproperty
	a_link_down: assert property (p_link_down) else $error("link down not flagged");
	property p_link_up;
		link_rise && link_up_detect_enable |=> link_change_flag;
	endproperty
	a_link_up: assert property (p_link_up) else $error("link up not flagged");
	property p_frame_pme;
		(frame_evt && frame_wake_enable && !wr_ctrl) ##1 s_quiet |=> power_event_status;
	endproperty
	a_frame_pme: assert property (p_frame_pme) else $error("wake frame gave no event");
	property p_pkt_pme;
		(pkt_evt && remote_wake_packet_enable && !wr_ctrl) ##1 s_quiet |=> power_event_status;
	endproperty
	a_pkt_pme: assert property (p_pkt_pme) else $error("wake packet gave no event");
	property p_link_pme;
		(link_evt && link_change_wake_enable && !wr_ctrl) ##1 s_quiet |=> power_event_status;
	endproperty
	a_link_pme: assert property (p_link_pme) else $error("link change gave no event");
	sequence s_kept(int b);
		flags[b] && !(wr_ctrl && bus.wdata[b]);
	endsequence
	property p_frame_hold;
		disable iff (pwr_on_rst) s_kept(`WUC_B_FRAME_FLAG) |=> flags[`WUC_B_FRAME_FLAG];
	endproperty
	a_frame_hold: assert property (p_frame_hold) else $error("frame flag dropped");
	property p_pkt_hold;
		disable iff (pwr_on_rst) s_kept(`WUC_B_PKT_FLAG) |=> flags[`WUC_B_PKT_FLAG];
	endproperty
	a_pkt_hold: assert property (p_pkt_hold) else $error("packet flag dropped");
	property p_link_hold;
		disable iff (pwr_on_rst) s_kept(`WUC_B_LINK_FLAG) |=> flags[`WUC_B_LINK_FLAG];
	endproperty
	a_link_hold: assert property (p_link_hold) else $error("link flag dropped");
	property p_flag_rst;
		disable iff (pwr_on_rst) sys_rst && !wr_ctrl |=> ((flags & $past(flags)) == $past(flags));
	endproperty
	a_flag_rst: assert property (p_flag_rst) else $error("system reset cleared a flag");
	property p_pdata_adv;
		wr_pdata |=> (wptr == ptr_inc($past(wptr)));
	endproperty
	a_pdata_adv: assert property (p_pdata_adv) else $error("data port index stuck");
	property p_mask_store;
		disable iff (pwr_on_rst) wr_pdata && !is_crc_word(wptr)
			|=> (filt[$past(wptr)] == $past(bus.wdata));
	endproperty
	a_mask_store: assert property (p_mask_store) else $error("mask word not stored");
	property p_crc_store;
		disable iff (pwr_on_rst) wr_pdata && is_crc_word(wptr)
			|=> (filt[$past(wptr)][15:8] == 8'h0) && (filt[$past(wptr)][31:16] == $past(bus.wdata[31:16]));
	endproperty
	a_crc_store: assert property (p_crc_store) else $error("crc word misstored");
	property p_seed;
		frame.valid && frame.sof && !pat_sel[0] |=> (crc[0] == $past(seed));
	endproperty
	a_seed: assert property (p_seed) else $error("crc start value wrong");
	property p_match;
		disable iff (pwr_on_rst) frame.valid && frame.eof && frame.ok && in_frame
			&& pat_hit[0] && pattern_one_wake_enable |=> wake_frame_seen_flag;
	endproperty
	a_match: assert property (p_match) else $error("pattern match not flagged");

endmodule
`default_nettype wire

// ### dv/wuc_net_model.sv
`timescale 1ns/100ps
`default_nettype none
module wuc_net_model import wuc_pkg::*; (
	// Clock
	input wire logic clock,
	// Frame bytes toward the block
	output var wuc_frame_s frame
);
	initial frame = '0;
	// Byte i of a frame carries 8'h10 + i; gap idles between bytes for a slow sender
	task automatic send(input int n, input logic good, input int gap);
		for (int i = 0; i < n; i++) begin
			@(posedge clock);
			frame <= '{1'b1, i == 0, i == n - 1, good, 8'h10 + 8'(i)};
			for (int g = 0; g < gap; g++) begin
				@(posedge clock);
				frame <= '{1'b0, 1'b0, 1'b0, 1'b0, ~frame.data};
			end
		end
		@(posedge clock);
		// Released line shows the inverse of the last byte when gap is even, the byte itself when odd
		frame <= '{1'b0, 1'b0, 1'b0, 1'b0, ~frame.data};
	endtask
endmodule
`default_nettype wire

// ### dv/tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "wuc_params.svh"
module tb import wuc_pkg::*; ;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic pwr_on_rst = 1'b1;
	wuc_bus_s bus = '0;
	logic remote_pkt_seen = 1'b0;
	logic link_up = 1'b0;
	logic [31:0] rdata;
	wuc_frame_s frame;
	logic power_event_status;
	logic irq;
	int failures = 0;
	int total_checks = 0;
	logic [31:0] e;
	logic [15:0] crc;
	always #20 clock = ~clock;
	wuc_top u_dut (.clock(clock), .sys_rst(sys_rst), .pwr_on_rst(pwr_on_rst), .bus(bus),
		.rdata(rdata), .frame(frame), .remote_pkt_seen(remote_pkt_seen), .link_up(link_up),
		.power_event_status(power_event_status), .irq(irq));
	wuc_net_model u_net (.clock(clock), .frame(frame));
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		total_checks++;
		if (g !== x) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", n, x, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clock);
		bus <= '{1'b1, 1'b0, a, v};
		@(posedge clock);
		bus <= '0;
	endtask
	task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] x);
		@(posedge clock);
		bus <= '{1'b0, 1'b1, a, 32'h0};
		@(posedge clock);
		bus <= '0;
		#1;
		chk(n, x, rdata);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask
	function automatic logic [31:0] pw(input int i, input bit rb);
		logic [31:0] v;
		v = (32'(i) * 32'h0101_0101) ^ 32'h5a5a_5a5a;
		if (rb && i % 5 == 4) v = v & `WUC_CRCW_KEEP;
		return v;
	endfunction
	function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c;
		for (int j = 7; j >= 0; j--) r = {r[14:0], 1'b0} ^ ((r[15] ^ b[j]) ? `WUC_CRC_POLY : 16'h0);
		return r;
	endfunction
	initial begin
		tick(20000);
		failures++;
		give_verdict();
	end
	initial begin
		tick(8);
		sys_rst <= 1'b0;
		pwr_on_rst <= 1'b0;
		rchk("ctrl reset", `WUC_CTRL_OFS, `WUC_CTRL_RSVD);
		rchk("mask reset", `WUC_IMASK_OFS, 32'h0);
		wr(`WUC_CTRL_OFS, 32'hffff_ffff);
		rchk("ctrl ones", `WUC_CTRL_OFS, `WUC_CTRL_WMASK | `WUC_CTRL_RSVD);
		wr(8'h6c, 32'hffff_ffff);
		rchk("unmapped", 8'h6c, 32'h0);
		// Fill all six patterns, read back with wrap to word 0
		wr(`WUC_PPTR_OFS, 32'h0);
		for (int i = 0; i < 30; i++) wr(`WUC_PDATA_OFS, pw(i, 0));
		wr(`WUC_PPTR_OFS, 32'h0);
		for (int i = 0; i <= 30; i++) rchk("pword", `WUC_PDATA_OFS, pw(i % 30, 1));
		wr(`WUC_CTRL_OFS, 32'h0001_0100);
		@(posedge clock);
		link_up <= 1'b1;
		tick(3);
		rchk("up flag", `WUC_CTRL_OFS, 32'h0001_0901);
		chk("pes link", 32'h1, 32'(power_event_status));
		wr(`WUC_CTRL_OFS, 32'h0001_0101);
		rchk("flag clear", `WUC_CTRL_OFS, 32'h0001_0900);
		chk("pes drop", 32'h0, 32'(power_event_status));
		@(posedge clock);
		link_up <= 1'b0;
		tick(3);
		rchk("down ignored", `WUC_CTRL_OFS, 32'h0001_0900);
		wr(`WUC_CTRL_OFS, 32'h0002_0100);
		@(posedge clock);
		link_up <= 1'b1;
		tick(3);
		rchk("up ignored", `WUC_CTRL_OFS, 32'h0002_0900);
		@(posedge clock);
		link_up <= 1'b0;
		tick(3);
		rchk("down flag", `WUC_CTRL_OFS, 32'h0002_0901);
		wr(`WUC_IMASK_OFS, 32'h1);
		rchk("mask", `WUC_IMASK_OFS, 32'h1);
		chk("irq on", 32'h1, 32'(irq));
		wr(`WUC_IMASK_OFS, 32'h6);
		rchk("mask", `WUC_IMASK_OFS, 32'h6);
		chk("irq masked", 32'h0, 32'(irq));
		wr(`WUC_CTRL_OFS, 32'h0000_0001);
		@(posedge clock);
		remote_pkt_seen <= 1'b1;
		@(posedge clock);
		remote_pkt_seen <= 1'b0;
		tick(2);
		rchk("pkt flag", `WUC_CTRL_OFS, 32'h0000_0802);
		chk("pes gated", 32'h0, 32'(power_event_status));
		chk("irq pkt", 32'h1, 32'(irq));
		wr(`WUC_CTRL_OFS, 32'h0000_0200);
		remote_pkt_seen <= 1'b1;
		@(posedge clock);
		remote_pkt_seen <= 1'b0;
		tick(2);
		chk("pes pkt", 32'h1, 32'(power_event_status));
		@(posedge clock);
		sys_rst <= 1'b1;
		tick(2);
		sys_rst <= 1'b0;
		rchk("flag kept", `WUC_CTRL_OFS, 32'h0000_0802);
		chk("irq mask rst", 32'h0, 32'(irq));
		@(posedge clock);
		pwr_on_rst <= 1'b1;
		tick(2);
		pwr_on_rst <= 1'b0;
		rchk("flag pwr", `WUC_CTRL_OFS, `WUC_CTRL_RSVD);
		rchk("pword pwr", `WUC_PDATA_OFS, 32'h0);
		// Pattern one picks bytes 2..5, both seeds, slow sender for seed one
		for (int s = 0; s < 2; s++) begin
			crc = s ? `WUC_SEED_ONE : `WUC_SEED_ZERO;
			for (int k = 0; k < 4; k++) crc = crc_byte(crc, 8'h12 + 8'(k));
			e = 32'h2000_0c00 | (32'(s) << 30);
			wr(`WUC_CTRL_OFS, e | 32'h4);
			wr(`WUC_PPTR_OFS, 32'h0);
			wr(`WUC_PDATA_OFS, 32'h0000_000f);
			for (int j = 0; j < 3; j++) wr(`WUC_PDATA_OFS, 32'h0);
			wr(`WUC_PDATA_OFS, {crc, 16'h0002});
			u_net.send(8, 1'b0, s);
			tick(2);
			rchk("bad frame", `WUC_CTRL_OFS, e);
			u_net.send(8, 1'b1, s);
			tick(2);
			rchk("match", `WUC_CTRL_OFS, e | 32'h4);
			chk("pes frame", 32'h1, 32'(power_event_status));
		end
		give_verdict();
	end
endmodule
`default_nettype wire
